// *** fdc_xfer_pkg.sv ***
// Package for the floppy sector transfer sequencer: commands, states, status bits, timing.
// Assumes a 10 MHz controller clock and a byte-level disk interface from a data separator.
package fdc_xfer_pkg;

  localparam int ClkHz = 10000000;
  // Head timing in microseconds, derived to cycles
  localparam int HeadLoadUs = 16000;
  localparam int HeadUnloadUs = 240000;
  localparam int HeadLoadCycles = (HeadLoadUs * (ClkHz / 1000000));
  localparam int HeadUnloadCycles = (HeadUnloadUs * (ClkHz / 1000000));

  localparam logic [1:0] TermNormal = 2'h0;
  localparam logic [1:0] TermAbnormal = 2'h1;
  localparam logic [7:0] FirstSector = 8'h01;
  localparam logic [7:0] ShortLenFull = 8'hff;
  localparam logic [10:0] MinSectorBytes = 11'h080;
  localparam logic [1:0] IndexLimit = 2'h2;

  // Status one bit positions
  localparam int S1NoIdBit = 0;
  localparam int S1NoDataBit = 2;
  localparam int S1EndCylBit = 7;
  localparam int S1CrcBit = 5;
  // Status two bit positions
  localparam int S2FieldCrcBit = 5;
  localparam int S2CtrlMarkBit = 6;

  typedef enum logic [1:0] {
    CmdReadData = 2'h0,
    CmdReadDeleted = 2'h1,
    CmdReadTrack = 2'h2,
    CmdWriteData = 2'h3
  } cmd_t;

  typedef enum logic [3:0] {
    StIdle = 4'h0,
    StHeadLoad = 4'h1,
    StWaitIndex = 4'h3,
    StSearch = 4'h2,
    StData = 4'h6,
    StCrc = 4'h7,
    StNext = 4'h5,
    StDone = 4'h4
  } state_t;

  typedef struct packed {
    cmd_t cmd;
    logic multiTrackFlag;
    logic passOverFlag;
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [2:0] sizeCode;
    logic [7:0] finalSectorNumber;
    logic [7:0] shortSectorLength;
  } cmd_params_t;

  typedef struct packed {
    logic [1:0] terminationCode;
    logic [7:0] statusOne;
    logic [7:0] statusTwo;
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [2:0] sizeCode;
  } result_t;

  // Disk side byte events from the data separator
  typedef struct packed {
    logic idValid;
    logic [7:0] idCyl;
    logic [7:0] idHead;
    logic [7:0] idSector;
    logic [2:0] idSize;
    logic idCrcOk;
    logic markValid;
    logic markDeleted;
    logic byteValid;
    logic [7:0] byteData;
    logic crcValid;
    logic crcOk;
  } disk_rx_t;

endpackage

// *** fdc_xfer_seq.sv ***
// Execution-phase sequencer for read data, read deleted, read track and write data.
// Assumes a data separator delivering decoded ID, mark, byte and CRC events on ref_clk,
// and a write encoder that appends CRC after a data field when asked.
//
// How it works
// - Multi-track continues head 0 onto head 1
// - Head stays loaded until unload interval expires
// - Two index pulses unfound: abnormal, no-data
// - Read CRC error: abnormal, crc fault, stop
// - Capacity bounded by final sector and heads
// - Read data: deleted, no skip, flag, stop
// - Read data: deleted with skip, pass over
// - Advance sector or cylinder after each sector
// - Read deleted mirrors skip rules, roles swapped
// - Read track starts at index, ignores numbering
// - Read track continues past CRC errors
// - Read track flags ID mismatch as no-data
// - Read track no ID by second index
// - Below final sector: report sector plus one
// - Single track at final: cylinder+1, sector 1
// - Multi-track at final: flip head, sector 1
// - Write loads head, matches ID, writes data
// - Write appends CRC then next sector
// - Terminal count or fifo fault pads zeros
// - Write ID CRC error ends abnormally
// - Write shares read capacity and result rules
// - Size code zero is 128 bytes, doubling per step; only the low two bits set the sector length
// - Read after terminal count finishes sector, checks CRC
`timescale 1ns/1ps

module fdc_xfer_seq
  import fdc_xfer_pkg::*;
#(
  parameter int HeadLoadCount = HeadLoadCycles,
  parameter int HeadUnloadCount = HeadUnloadCycles
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command start and parameters
  input wire logic start,
  input wire cmd_params_t params,
  output logic busy,
  output logic done,
  output result_t result,
  // Drive pins
  input wire logic index_pulse_n,
  output logic headLoad,
  output logic writeGate,
  // Disk receive events
  input wire disk_rx_t diskRx,
  // Disk write byte stream
  output logic wrValid,
  output logic [7:0] wrData,
  output logic wrCrc,
  input wire logic wrReady,
  // Host FIFO, read direction
  output logic rdValid,
  output logic [7:0] rdData,
  input wire logic rdReady,
  // Host FIFO, write direction
  input wire logic hostValid,
  input wire logic [7:0] hostData,
  output logic hostReady,
  // Terminal count and fifo fault
  input wire logic terminal_count,
  input wire logic fifoFault
);

  // Both head intervals share one 24-bit down counter, so larger counts would wrap
  if (HeadLoadCount < 1 || HeadLoadCount > 2 ** 24 - 1) begin : g_bad_load
    $error("fdc_xfer_seq: head load count out of range");
  end
  if (HeadUnloadCount < 1 || HeadUnloadCount > 2 ** 24 - 1) begin : g_bad_unload
    $error("fdc_xfer_seq: head unload count out of range");
  end

  typedef struct packed {
    state_t state;
    cmd_params_t p;
    logic [1:0] idxCnt;
    logic [1:0] idxSync;
    logic idxLast;
    logic headUp;
    logic [23:0] headTmr;
    logic [10:0] byteCnt;
    logic hostStop;
    logic advance;
    logic endAfter;
    logic anyId;
    logic [1:0] term;
    logic [7:0] s1;
    logic [7:0] s2;
    logic doneP;
    logic rdV;
    logic [7:0] rdD;
    logic wrV;
    logic [7:0] wrD;
    logic crcP;
    logic wg;
    result_t res;
  } state_reg_t;

  state_reg_t q, d;
  logic idxEdge;
  logic [10:0] secBytes;
  logic [10:0] hostBytes;
  logic idMatch;
  logic atFinal;
  logic skipMark;
  logic stopMark;
  logic hostHalt;
  logic hostTake;
  logic rdTake;

  // Idle value of every state field
  // Index pin idles high, so the edge detector starts high to avoid a false edge
  localparam state_reg_t ResetState = '{
    state: StIdle, p: '0, idxCnt: 2'h0,
    idxSync: 2'h3, idxLast: 1'b1,
    headUp: 1'b0, headTmr: 24'h0, byteCnt: 11'h0,
    hostStop: 1'b0, advance: 1'b0, endAfter: 1'b0, anyId: 1'b0,
    term: 2'h0, s1: 8'h0, s2: 8'h0, doneP: 1'b0,
    rdV: 1'b0, rdD: 8'h0, wrV: 1'b0, wrD: 8'h0,
    crcP: 1'b0, wg: 1'b0, res: '0
  };

  always_comb begin
    // Sector length from size code
    secBytes = 11'(MinSectorBytes << q.p.sizeCode[1:0]);
    hostBytes = (q.p.sizeCode == 3'h0 && q.p.shortSectorLength < 8'h80) ?
      {3'h0, q.p.shortSectorLength} : secBytes;
    // Falling edge of the synchronised index pin
    idxEdge = q.idxLast && !q.idxSync[1];
    idMatch = diskRx.idCyl == q.p.cyl && diskRx.idHead == q.p.head &&
      diskRx.idSector == q.p.sector && diskRx.idSize == q.p.sizeCode;
    atFinal = q.p.sector == q.p.finalSectorNumber;
    // Mark that the command does not want; read track takes every mark as it comes
    case (q.p.cmd)
      CmdReadData: skipMark = diskRx.markDeleted;
      CmdReadDeleted: skipMark = !diskRx.markDeleted;
      default: skipMark = 1'b0;
    endcase
    stopMark = skipMark && !q.p.passOverFlag;
    // Host stop seen now or earlier in this command
    hostHalt = q.hostStop || terminal_count || fifoFault;
    // One host byte per disk slot; hostReady uses the same term so no byte is lost
    hostTake = q.state == StData && q.p.cmd == CmdWriteData && (!q.wrV || wrReady) &&
      !hostHalt && q.byteCnt < hostBytes;
    // Host sees bytes only before its stop and within a short sector length
    rdTake = diskRx.byteValid && !hostHalt && q.byteCnt < hostBytes;

    d = q;
    d.idxSync = {q.idxSync[0], index_pulse_n};
    d.idxLast = q.idxSync[1];
    d.doneP = 1'b0;
    d.crcP = 1'b0;
    // No back-pressure toward the disk: a slow host loses the byte
    if (q.rdV && rdReady) d.rdV = 1'b0;
    if (q.wrV && wrReady) d.wrV = 1'b0;
    // Sticky until the next start
    if (hostHalt) d.hostStop = 1'b1;

    // Head unload timing while idle
    if (q.state == StIdle && q.headUp) begin
      if (q.headTmr == 24'h0) d.headUp = 1'b0;
      else d.headTmr = q.headTmr - 24'h1;
    end

    case (q.state)
      StIdle: begin
        if (start) begin
          d.p = params;
          d.term = TermNormal;
          d.s1 = 8'h0;
          d.s2 = 8'h0;
          d.hostStop = 1'b0;
          d.idxCnt = 2'h0;
          d.anyId = 1'b0;
          d.advance = 1'b0;
          d.endAfter = 1'b0;
          // Loaded head skips the settle wait
          if (q.headUp) begin
            // Start wins over an unload falling due in the same cycle
            d.headUp = 1'b1;
            d.state = (params.cmd == CmdReadTrack) ? StWaitIndex : StSearch;
          end else begin
            d.headUp = 1'b1;
            d.headTmr = 24'(HeadLoadCount);
            d.state = StHeadLoad;
          end
        end
      end
      StHeadLoad: begin
        if (q.headTmr == 24'h0) begin
          d.state = (q.p.cmd == CmdReadTrack) ? StWaitIndex : StSearch;
        end else begin
          d.headTmr = q.headTmr - 24'h1;
        end
      end
      StWaitIndex: begin
        // Track read starts on the index pulse
        if (idxEdge) begin
          d.idxCnt = 2'h1;
          d.state = StSearch;
        end
      end
      StSearch: begin
        if (idxEdge) d.idxCnt = q.idxCnt + 2'h1;
        if (idxEdge && q.idxCnt + 2'h1 >= IndexLimit) begin
          d.term = TermAbnormal;
          if (q.p.cmd == CmdReadTrack && !q.anyId) d.s1[S1NoIdBit] = 1'b1;
          else d.s1[S1NoDataBit] = 1'b1;
          d.state = StDone;
        end else if (diskRx.idValid) begin
          d.anyId = 1'b1;
          if (!diskRx.idCrcOk && q.p.cmd != CmdReadTrack) begin
            d.term = TermAbnormal;
            d.s1[S1CrcBit] = 1'b1;
            if (q.p.cmd != CmdWriteData) d.s2[S2FieldCrcBit] = 1'b1;
            d.state = StDone;
          end else if (q.p.cmd == CmdReadTrack) begin
            if (!diskRx.idCrcOk) begin
              d.s1[S1CrcBit] = 1'b1;
              d.s2[S2FieldCrcBit] = 1'b1;
            end
            if (!idMatch) d.s1[S1NoDataBit] = 1'b1;
            d.byteCnt = 11'h0;
            d.state = StData;
          end else if (idMatch) begin
            d.idxCnt = 2'h0;
            if (q.p.cmd == CmdWriteData) d.wg = 1'b1;
            d.byteCnt = 11'h0;
            d.state = StData;
          end
        end
      end
      StData: begin
        if (q.p.cmd == CmdWriteData) begin
          // Write data field; host stalls only via wrReady
          d.wg = 1'b1;
          if (!q.wrV || wrReady) begin
            d.wrV = 1'b1;
            if (hostTake) begin
              d.wrD = hostData;
            end else begin
              d.wrD = 8'h00;
            end
            d.byteCnt = q.byteCnt + 11'h1;
            if (q.byteCnt + 11'h1 == secBytes) begin
              d.crcP = 1'b1;
              d.advance = 1'b1;
              d.endAfter = hostHalt;
              d.state = StNext;
            end
          end
        end else if (q.byteCnt == 11'h0 && !diskRx.markValid && !diskRx.byteValid) begin
          d.state = StData;
        end else if (diskRx.markValid) begin
          if (skipMark) d.s2[S2CtrlMarkBit] = 1'b1;
          if (q.p.cmd == CmdReadTrack) begin
            d.advance = 1'b0;
          end else if (skipMark && q.p.passOverFlag) begin
            d.advance = 1'b1;
            d.state = StNext;
          end else begin
            d.advance = !stopMark;
            d.endAfter = stopMark;
          end
        end else if (diskRx.byteValid) begin
          // Keep reading after host stop
          if (rdTake) begin
            d.rdV = 1'b1;
            d.rdD = diskRx.byteData;
          end
          d.byteCnt = q.byteCnt + 11'h1;
          if (q.byteCnt + 11'h1 == secBytes) d.state = StCrc;
        end
      end
      StCrc: begin
        if (diskRx.crcValid) begin
          if (!diskRx.crcOk) begin
            d.s1[S1CrcBit] = 1'b1;
            if (q.p.cmd != CmdReadTrack) begin
              d.term = TermAbnormal;
              d.state = StDone;
            end else begin
              d.state = StNext;
            end
          end else begin
            if (q.p.cmd != CmdReadTrack) d.advance = !d.endAfter;
            d.state = StNext;
          end
          if (q.p.cmd == CmdReadTrack) d.advance = 1'b1;
        end
      end
      StNext: begin
        d.wg = 1'b0;
        if (!q.advance || q.endAfter || q.hostStop) begin
          d.state = StDone;
          if (q.advance) begin
            // Result ID after host termination
            if (!atFinal) begin
              d.p.sector = q.p.sector + 8'h1;
            end else begin
              d.p.sector = FirstSector;
              if (q.p.multiTrackFlag) d.p.head = {q.p.head[7:1], !q.p.head[0]};
              if (!q.p.multiTrackFlag || q.p.head[0]) d.p.cyl = q.p.cyl + 8'h1;
            end
          end
        end else if (q.p.cmd == CmdReadTrack) begin
          d.p.sector = q.p.sector + 8'h1;
          if (atFinal) d.state = StDone;
          else d.state = StSearch;
        end else if (!atFinal) begin
          d.p.sector = q.p.sector + 8'h1;
          d.state = StSearch;
        end else if (q.p.multiTrackFlag && !q.p.head[0]) begin
          d.p.sector = FirstSector;
          d.p.head = {q.p.head[7:1], 1'b1};
          d.state = StSearch;
        end else begin
          // Capacity reached without host stop: end of cylinder
          d.p.sector = FirstSector;
          d.p.cyl = q.p.cyl + 8'h1;
          if (q.p.multiTrackFlag) d.p.head = {q.p.head[7:1], 1'b0};
          d.term = TermAbnormal;
          d.s1[S1EndCylBit] = 1'b1;
          d.state = StDone;
        end
        d.idxCnt = 2'h0;
      end
      StDone: begin
        d.wg = 1'b0;
        d.res.terminationCode = q.term;
        d.res.statusOne = q.s1;
        d.res.statusTwo = q.s2;
        d.res.cyl = q.p.cyl;
        d.res.head = q.p.head;
        d.res.sector = q.p.sector;
        d.res.sizeCode = q.p.sizeCode;
        d.doneP = 1'b1;
        d.headTmr = 24'(HeadUnloadCount);
        d.state = StIdle;
      end
      default: d.state = StIdle;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= ResetState;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign busy = q.state != StIdle;
  assign done = q.doneP;
  assign result = q.res;
  assign headLoad = q.headUp;
  assign writeGate = q.wg;
  assign wrValid = q.wrV;
  assign wrData = q.wrD;
  assign wrCrc = q.crcP;
  assign rdValid = q.rdV;
  assign rdData = q.rdD;
  // Host byte consumed when a data byte is written; a stop in this cycle takes none
  assign hostReady = hostTake;

endmodule // fdc_xfer_seq

// *** fdc_xfer_seq_sva.sv ***
// Port-level checker for the floppy sector transfer sequencer.
// Assumes one clock ref_clk and the active-high asynchronous reset rst.
`timescale 1ns/1ps

module fdc_xfer_seq_sva
  import fdc_xfer_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command side
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire result_t result,
  // Drive and streams
  input wire logic headLoad,
  input wire logic writeGate,
  input wire logic wrValid,
  input wire logic [7:0] wrData,
  input wire logic wrCrc,
  input wire logic wrReady,
  input wire logic hostReady
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  start_taken_a: assert property (start && !busy |=> busy) else $error("start not taken");
  done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
  result_stands_a: assert property (!done |-> $stable(result)) else $error("result moved without done");
  abnormal_flag_a: assert property (done && result.terminationCode == TermAbnormal |-> result.statusOne != 8'h00)
    else $error("abnormal end without cause");
  head_kept_a: assert property (done && headLoad |=> headLoad [*8]) else $error("head unloaded early");
  gate_head_a: assert property (writeGate |-> headLoad) else $error("write gate without head");
  host_gate_a: assert property (hostReady |-> writeGate) else $error("host byte outside field");
  write_hold_a: assert property (wrValid && !wrReady |=> wrValid && $stable(wrData))
    else $error("disk byte dropped");
  crc_pulse_a: assert property (wrCrc |=> !wrCrc) else $error("crc request too long");
  idle_gate_a: assert property (!busy |-> !writeGate) else $error("write gate while idle");

  cover property (done && result.terminationCode == TermAbnormal);
  cover property (wrCrc);
  cover property (wrValid && !wrReady);
endmodule // fdc_xfer_seq_sva

bind fdc_xfer_seq fdc_xfer_seq_sva chk (.ref_clk, .rst, .start, .busy, .done, .result, .headLoad,
  .writeGate, .wrValid, .wrData, .wrCrc, .wrReady, .hostReady);

// *** fdc_disk_model.sv ***
// Drive and data separator stand-in: index pulses, ID, mark, byte and CRC events.
// Assumes its tasks are called just after a rising edge of ref_clk.
`timescale 1ns/1ps

module fdc_disk_model
  import fdc_xfer_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Drive side
  output disk_rx_t diskRx,
  output logic index_pulse_n,
  output logic wrReady,
  input wire logic wrValid,
  input wire logic [7:0] wrData
);
  int nWr = 0;
  int nZero = 0;
  logic [1:0] ph = 2'h0;
  initial diskRx = '0;
  initial index_pulse_n = 1'b1;

  // Encoder stalls one cycle in three
  assign wrReady = ph != 2'h2;
  always @(posedge ref_clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (wrValid && wrReady) begin
      nWr++;
      nZero += (wrData == 8'h00);
    end
  end

  // One event, then an idle cycle
  task automatic ev(input disk_rx_t e);
    diskRx <= e;
    @(posedge ref_clk);
    diskRx <= '0;
    @(posedge ref_clk);
  endtask

  task automatic idf(input logic [7:0] c, h, s, input logic ok);
    ev('{1'b1, c, h, s, 3'h0, ok, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0});
  endtask

  // Mark, 128 bytes, CRC verdict
  task automatic sec(input logic del, ok);
    ev('{1'b0, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0, 1'b1, del, 1'b0, 8'h00, 1'b0, 1'b0});
    for (int i = 0; i < 128; i++) begin
      ev('{1'b0, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 8'(i + 1), 1'b0, 1'b0});
    end
    ev('{1'b0, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1, ok});
  endtask

  task automatic idx();
    index_pulse_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    index_pulse_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask
endmodule // fdc_disk_model

// *** fdc_xfer_seq_tb.sv ***
// Self-checking bench for the floppy sector transfer sequencer.
// Assumes a disk model on the drive side and a host FIFO that is never empty.
`timescale 1ns/1ps

module fdc_xfer_seq_tb;
  import fdc_xfer_pkg::*;
  logic ref_clk, rst, start, busy, done, index_pulse_n, headLoad, writeGate;
  logic wrValid, wrCrc, wrReady, rdValid, rdReady, hostValid, hostReady, terminal_count, fifoFault;
  logic [7:0] wrData, rdData, hostData;
  cmd_params_t params;
  result_t result;
  disk_rx_t diskRx;
  int fails = 0;
  int n_tests = 0;
  int nRd, nHost, nCrc, tcAt, w0, z0;
  logic wrTc, doneSeen;

  fdc_xfer_seq #(.HeadLoadCount(4), .HeadUnloadCount(20)) DUT (.ref_clk, .rst, .start, .params, .busy,
    .done, .result, .index_pulse_n, .headLoad, .writeGate, .diskRx, .wrValid, .wrData, .wrCrc,
    .wrReady, .rdValid, .rdData, .rdReady, .hostValid, .hostData, .hostReady, .terminal_count, .fifoFault);
  fdc_disk_model disk (.ref_clk, .diskRx, .index_pulse_n, .wrReady, .wrValid, .wrData);

  // Host stops on its last wanted byte; write side one cycle late
  assign terminal_count = (rdValid && nRd == tcAt - 1) || wrTc;
  always @(posedge ref_clk) begin
    if (rdValid && rdReady) nRd <= nRd + 1;
    if (hostReady && hostValid) nHost <= nHost + 1;
    if (wrCrc) nCrc <= nCrc + 1;
    if (done) doneSeen <= 1'b1;
    wrTc <= hostReady && nHost + 1 == tcAt;
  end

  task automatic results();
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic res(input logic [7:0] c, h, r);
    chk({6'h00, result.terminationCode, result.cyl, result.head, result.sector}, {6'h00, TermNormal, c, h, r});
  endtask

  task automatic flg(input logic [31:0] m, e);
    chk({14'h0000, result.terminationCode, result.statusOne, result.statusTwo} & m, e);
  endtask

  task automatic go(input cmd_t c, input logic mt, sk, input logic [7:0] h, r, f, input int tc);
    @(posedge ref_clk);
    params <= '{c, mt, sk, 8'h05, h, r, 3'h0, f, ShortLenFull};
    start <= 1'b1;
    tcAt <= tc;
    nRd <= 0;
    nHost <= 0;
    nCrc <= 0;
    doneSeen <= 1'b0;
    @(posedge ref_clk);
    start <= 1'b0;
    // Head load count is 4 here
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic waitDone();
    int i;
    // Sticky flag: the pulse may pass while the disk model still runs
    for (i = 0; i < 4000 && doneSeen !== 1'b1; i++) @(posedge ref_clk);
    chk({31'h0, doneSeen}, 32'h1);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    #5ms;
    fails++;
    results();
  end

  initial begin
    rst = 1'b1;
    start = 1'b0;
    params = '0;
    rdReady = 1'b1;
    hostValid = 1'b1;
    hostData = 8'ha5;
    fifoFault = 1'b0;
    tcAt = 0;
    nRd = 0;
    nHost = 0;
    nCrc = 0;
    wrTc = 1'b0;
    doneSeen = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    // Two sectors up to the final one
    go(CmdReadData, 0, 0, 8'h00, 8'h01, 8'h02, 256);
    disk.idf(8'h05, 8'h00, 8'h01, 1);
    disk.sec(0, 1);
    disk.idf(8'h05, 8'h00, 8'h02, 1);
    disk.sec(0, 1);
    waitDone();
    res(8'h06, 8'h00, 8'h01);
    chk(32'(nRd), 32'h100);
    // Host stops mid-sector below the final sector
    go(CmdReadData, 0, 0, 8'h00, 8'h03, 8'h09, 100);
    disk.idf(8'h05, 8'h00, 8'h03, 1);
    disk.sec(0, 1);
    waitDone();
    res(8'h05, 8'h00, 8'h04);
    chk(32'(nRd), 32'h64);
    // Multi-track crosses from head 0 to head 1
    go(CmdReadData, 1, 0, 8'h00, 8'h02, 8'h02, 256);
    disk.idf(8'h05, 8'h00, 8'h02, 1);
    disk.sec(0, 1);
    disk.idf(8'h05, 8'h01, 8'h01, 1);
    disk.sec(0, 1);
    waitDone();
    chk({16'h0000, result.cyl, result.sector}, 32'h0502);
    chk(32'(nRd), 32'h100);
    for (int k = 0; k < 2; k++) begin
      go(CmdReadData, 1, 0, 8'(k), 8'h02, 8'h02, 128);
      disk.idf(8'h05, 8'(k), 8'h02, 1);
      disk.sec(0, 1);
      waitDone();
      res(8'(5 + k), 8'(1 - k), 8'h01);
    end
    // Unwanted mark, with and without pass-over, both read commands
    for (int k = 0; k < 4; k++) begin
      go(k[1] ? CmdReadDeleted : CmdReadData, 0, k[0], 8'h00, 8'h03, 8'h09, k[0] ? 128 : 0);
      disk.idf(8'h05, 8'h00, 8'h03, 1);
      disk.sec(!k[1], 1);
      if (k[0]) begin
        disk.idf(8'h05, 8'h00, 8'h04, 1);
        disk.sec(k[1], 1);
      end
      waitDone();
      flg(32'h00030040, 32'h00000040);
      chk(32'(nRd), 32'h80);
    end
    // Data CRC, then ID CRC
    go(CmdReadData, 0, 0, 8'h00, 8'h03, 8'h09, 0);
    disk.idf(8'h05, 8'h00, 8'h03, 1);
    disk.sec(0, 0);
    waitDone();
    flg(32'h00032020, 32'h00012000);
    go(CmdReadData, 0, 0, 8'h00, 8'h03, 8'h09, 0);
    disk.idf(8'h05, 8'h00, 8'h03, 0);
    waitDone();
    flg(32'h00032020, 32'h00012020);
    // Final sector reached with no host stop: end of cylinder
    go(CmdReadData, 0, 0, 8'h00, 8'h09, 8'h09, 0);
    disk.idf(8'h05, 8'h00, 8'h09, 1);
    disk.sec(0, 1);
    waitDone();
    flg(32'h00038000, 32'h00018000);
    chk({16'h0000, result.cyl, result.sector}, 32'h0601);
    // Sector never found
    go(CmdReadData, 0, 0, 8'h00, 8'h07, 8'h09, 0);
    disk.idx();
    disk.idf(8'h05, 8'h00, 8'h01, 1);
    disk.idx();
    disk.idx();
    waitDone();
    flg(32'h00030400, 32'h00010400);
    // Whole track with a foreign ID and a bad data CRC
    go(CmdReadTrack, 0, 0, 8'h00, 8'h01, 8'h01, 0);
    disk.idx();
    disk.idf(8'h05, 8'h00, 8'h09, 1);
    disk.sec(0, 0);
    waitDone();
    flg(32'h00002440, 32'h00002400);
    chk(32'(nRd), 32'h80);
    go(CmdReadTrack, 0, 0, 8'h00, 8'h01, 8'h01, 0);
    repeat (3) disk.idx();
    waitDone();
    flg(32'h00030100, 32'h00010100);
    // Write stopped by the host after 50 bytes
    w0 = disk.nWr;
    z0 = disk.nZero;
    go(CmdWriteData, 0, 0, 8'h00, 8'h03, 8'h09, 50);
    disk.idf(8'h05, 8'h00, 8'h03, 1);
    waitDone();
    res(8'h05, 8'h00, 8'h04);
    chk(32'(disk.nWr - w0), 32'h80);
    chk(32'(nHost), 32'h32);
    chk(32'(disk.nZero - z0), 32'h4e);
    chk(32'(nCrc), 32'h1);
    go(CmdWriteData, 0, 0, 8'h00, 8'h03, 8'h09, 0);
    disk.idf(8'h05, 8'h00, 8'h03, 0);
    waitDone();
    flg(32'h00032000, 32'h00012000);
    results();
  end
endmodule // fdc_xfer_seq_tb
